/* File: bench/fewc_flash_model.sv */
// behavioural byte-wide flash device seen by the host
`timescale 1ns/10ps
`default_nettype none
module fewc_flash_model
    import fewc_pkg::*;
(
    input wire fewc_pkg::fewc_pins_s pins, // host pin drive
    input wire logic reset_powerdown_n, // reset pin
    input wire logic boot_protect, // boot protect pin
    input wire logic supply_low, // program supply low
    output logic [fewc_pkg::DATA_W-1:0] dq // data to host
);
    import fewc_pkg::*;
    logic [7:0] mem [0:15];
    logic [7:0] sts;
    logic [7:0] setup;
    logic [7:0] lat;
    logic show_sts;
    function automatic int idx(input logic [19:0] a);
        return {a[16], a[2:0]};
    endfunction : idx
    // ------------------------------------------------------------
    // decode on write strobe rise
    // ------------------------------------------------------------
    always @(posedge pins.we_n or negedge reset_powerdown_n) begin
        if (!reset_powerdown_n) begin
            sts <= 8'h80;
            setup <= 8'h00;
            show_sts <= 1'b0;
            for (int i = 0; i < 16; i++) mem[i] <= 8'hff;
        end else if (setup != 8'h00) begin
            setup <= 8'h00;
            show_sts <= 1'b1;
            if (setup == 8'h40 || setup == 8'h10) begin
                if (supply_low) sts <= sts | 8'h18;
                else if (!boot_protect && !pins.addr[16]) sts <= sts | 8'h12;
                else begin
                    mem[idx(pins.addr)] <= mem[idx(pins.addr)] & pins.dq_out;
                    sts[7] <= 1'b0;
                    sts[7] <= #400 1'b1;
                end
            end else if (pins.dq_out != CMD_CONFIRM) sts <= sts | 8'h30;
            else if (supply_low) sts <= sts | 8'h28;
            else if (setup == 8'h20 && !boot_protect && !pins.addr[16]) begin
                sts <= sts | 8'h22;
            end else begin
                for (int i = 0; i < 16; i++) begin
                    if ((setup == 8'h30 || i[3] == pins.addr[16]) && (i[3] || boot_protect))
                        mem[i] <= 8'hff;
                end
                sts[7] <= 1'b0;
                sts[7] <= #400 1'b1;
            end
        end else if (sts[7] || pins.dq_out == CMD_SUSPEND) begin
            case (pins.dq_out)
                8'hff: show_sts <= 1'b0;
                8'h70, 8'hd0: show_sts <= 1'b1;
                8'h50: sts <= sts & 8'hc5;
                8'hb0: show_sts <= 1'b0;
                8'h20, 8'h30, 8'h40, 8'h10: setup <= pins.dq_out;
                default: ;
            endcase
        end
    end
    always @(negedge pins.oe_n) lat <= show_sts ? sts : mem[idx(pins.addr)];
    assign dq = (!pins.ce_n && !pins.oe_n) ? lat : ~lat;
endmodule : fewc_flash_model
`default_nettype wire

/* File: bench/tb_fewc_host.sv */
// register-level bench of the flash command host
`timescale 1ns/10ps
`default_nettype none
module tb_fewc_host;
    import fewc_pkg::*;
    logic core_clk, rst, reg_wr, reg_rd, supply_low, reset_powerdown_n, boot_protect;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    fewc_pins_s flash_pins;
    logic [7:0] flash_dq_in;
    int fail_count, total_checks, cyc;
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    fewc_host i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flash_pins(flash_pins), .flash_dq_in(flash_dq_in),
        .reset_powerdown_n(reset_powerdown_n), .boot_protect(boot_protect));
    fewc_flash_model i_flash (.pins(flash_pins), .reset_powerdown_n(reset_powerdown_n),
        .boot_protect(boot_protect), .supply_low(supply_low), .dq(flash_dq_in));
    task complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
        @(posedge core_clk);
        #1 check(reg_rdata, 32'h0);
    endtask : reg_read
    task run_op(input logic [3:0] op);
        reg_write(REG_CTRL, {28'h0, op});
        rd = 32'h0;
        for (int n = 0; n < 400 && rd[STS_DONE] !== 1'b1; n++) reg_read(REG_STATUS);
    endtask : run_op
    task byte_at(input logic [19:0] a, input logic [7:0] d, input logic [31:0] exp);
        reg_write(REG_ADDR, {12'h0, a});
        reg_write(REG_WDATA, {24'h0, d});
        run_op(OP_BYTE_WRITE);
        check(rd, exp);
    endtask : byte_at
    task read_at(input logic [19:0] a, input logic [7:0] exp);
        reg_write(REG_ADDR, {12'h0, a});
        run_op(OP_READ_ARRAY);
        reg_read(REG_RDATA);
        check(rd, {24'h0, exp});
    endtask : read_at
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, supply_low, reg_addr, reg_wdata} = '0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        reg_read(REG_PINS);
        check(rd, 32'h1);
        reg_read(8'hfc);
        check(rd, 32'h0);
        reg_write(REG_PINS, 32'h0);
        reg_write(REG_PINS, 32'h1);
        read_at(20'h10005, 8'hff);
        byte_at(20'h10005, 8'h5a, 32'h880);
        byte_at(20'h10005, 8'h0f, 32'h880);
        read_at(20'h10005, 8'h0a);
        run_op(OP_BLOCK_ERASE);
        check(rd, 32'h880);
        read_at(20'h10005, 8'hff);
        supply_low <= 1'b1;
        run_op(OP_BLOCK_ERASE);
        check(rd, 32'h8a8);
        byte_at(20'h10005, 8'h00, 32'h8b8);
        supply_low <= 1'b0;
        run_op(OP_CLEAR);
        run_op(OP_READ_STATUS);
        check(rd, 32'h880);
        reg_write(REG_ADDR, 32'h3);
        run_op(OP_BLOCK_ERASE);
        check(rd, 32'h8a2);
        byte_at(20'h00003, 8'h00, 32'h8b2);
        run_op(OP_CLEAR);
        reg_write(REG_PINS, 32'h3);
        byte_at(20'h00003, 8'h33, 32'h880);
        byte_at(20'h10005, 8'h00, 32'h880);
        reg_write(REG_PINS, 32'h1);
        run_op(OP_CHIP_ERASE);
        check(rd, 32'h880);
        read_at(20'h00003, 8'h33);
        read_at(20'h10005, 8'hff);
        reg_write(REG_CTRL, {28'h0, OP_CHIP_ERASE});
        reg_write(REG_CTRL, {28'h0, OP_READ_STATUS});
        run_op(OP_READ_STATUS);
        check(rd[STS_REFUSED], 1'b1);
        run_op(OP_SUSPEND);
        check(rd, 32'h880);
        run_op(OP_RESUME);
        check(rd, 32'h880);
        complete_run();
    end
endmodule : tb_fewc_host
`default_nettype wire

/* File: include/fewc_pkg.sv */
// constants and types of the flash command host
package fewc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int T_SETUP_NS = 40;
    localparam int T_PULSE_NS = 100;
    localparam int T_HOLD_NS = 40;
    localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int SYNC_STAGES = 2;
    localparam int RD_PULSE_CYC = PULSE_CYC + SYNC_STAGES;
    localparam int CNT_W = 3;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    // ------------------------------------------------------------
    // command bytes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
    localparam logic [7:0] CMD_BYTE_WRITE = 8'h40;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_CONFIRM = 8'hd0;
    // ------------------------------------------------------------
    // device status bits
    // ------------------------------------------------------------
    localparam int BIT_READY = 7;
    localparam int BIT_ERASE_SUSP = 6;
    localparam int BIT_WRITE_SUSP = 2;
    // ------------------------------------------------------------
    // host registers
    // ------------------------------------------------------------
    localparam int REG_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_PINS = 8'h14;
    localparam int STS_BUSY = 8;
    localparam int STS_SUSP = 9;
    localparam int STS_REFUSED = 10;
    localparam int STS_DONE = 11;
    localparam int PIN_RP = 0;
    localparam int PIN_WP = 1;
    localparam logic RP_RESET = 1'b1;
    localparam logic WP_RESET = 1'b0;

    typedef enum logic [3:0] {
        OP_READ_ARRAY = 4'h0,
        OP_READ_STATUS = 4'h1,
        OP_CLEAR = 4'h2,
        OP_BLOCK_ERASE = 4'h3,
        OP_CHIP_ERASE = 4'h4,
        OP_BYTE_WRITE = 4'h5,
        OP_SUSPEND = 4'h6,
        OP_RESUME = 4'h7
    } fewc_op_e;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } fewc_pins_s;

    localparam fewc_pins_s PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
        addr: 20'h00000, dq_out: 8'h00, dq_oe: 1'b0};
endpackage : fewc_pkg

/* File: src/fewc_bus_cycle.sv */
// one strobed write or read cycle on the flash pins
`timescale 1ns/10ps
`default_nettype none
module fewc_bus_cycle
    import fewc_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst, // async reset
    input wire logic start, // begin a cycle
    input wire logic is_read, // read when high
    input wire logic [fewc_pkg::ADDR_W-1:0] cyc_addr, // address
    input wire logic [fewc_pkg::DATA_W-1:0] cyc_data, // write byte
    input wire logic [fewc_pkg::DATA_W-1:0] dq_sync, // synced data pins
    output fewc_pkg::fewc_pins_s pins, // pin drive
    output logic done, // cycle over pulse
    output logic [fewc_pkg::DATA_W-1:0] rd_byte // byte read
);
    import fewc_pkg::*;

    // refuse timing counts that the counter cannot serve
    if (RD_PULSE_CYC > 8 || SETUP_CYC < 1 || HOLD_CYC < 1) begin : g_timing_chk
        $error("bus timing does not fit counter");
    end

    typedef enum logic [1:0] {
        BS_IDLE = 2'b00,
        BS_SETUP = 2'b01,
        BS_PULSE = 2'b10,
        BS_HOLD = 2'b11
    } fewc_bus_e;

    fewc_bus_e state_reg, state_next;
    fewc_pins_s pins_reg, pins_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic rd_reg, rd_next;
    logic done_reg, done_next;
    logic [DATA_W-1:0] byte_reg, byte_next;

    always_comb begin
        state_next = state_reg;
        pins_next = pins_reg;
        cnt_next = cnt_reg;
        rd_next = rd_reg;
        done_next = 1'b0;
        byte_next = byte_reg;
        case (state_reg)
            BS_IDLE: begin
                if (start) begin
                    pins_next = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1,
                        addr: cyc_addr, dq_out: cyc_data, dq_oe: !is_read};
                    rd_next = is_read;
                    cnt_next = CNT_W'(SETUP_CYC - 1);
                    state_next = BS_SETUP;
                end
            end
            BS_SETUP: begin
                if (cnt_reg == '0) begin
                    pins_next.oe_n = !rd_reg;
                    pins_next.we_n = rd_reg;
                    cnt_next = rd_reg ? CNT_W'(RD_PULSE_CYC - 1) : CNT_W'(PULSE_CYC - 1);
                    state_next = BS_PULSE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            BS_PULSE: begin
                if (cnt_reg == '0) begin
                    // write byte latches on this rising strobe
                    if (rd_reg) begin
                        byte_next = dq_sync;
                    end
                    pins_next.oe_n = 1'b1;
                    pins_next.we_n = 1'b1; // RL12
                    cnt_next = CNT_W'(HOLD_CYC - 1);
                    state_next = BS_HOLD;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            BS_HOLD: begin
                if (cnt_reg == '0) begin
                    pins_next = PINS_IDLE;
                    done_next = 1'b1;
                    state_next = BS_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                pins_next = PINS_IDLE;
                state_next = BS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= BS_IDLE;
            pins_reg <= PINS_IDLE;
            cnt_reg <= '0;
            rd_reg <= 1'b0;
            done_reg <= 1'b0;
            byte_reg <= '0;
        end else begin
            state_reg <= state_next;
            pins_reg <= pins_next;
            cnt_reg <= cnt_next;
            rd_reg <= rd_next;
            done_reg <= done_next;
            byte_reg <= byte_next;
        end
    end

    assign pins = pins_reg;
    assign done = done_reg;
    assign rd_byte = byte_reg;

    we_pulse_width_a: assert property (@(posedge core_clk) disable iff (rst) // RL12
        $fell(pins_reg.we_n) |-> (!pins_reg.we_n && pins_reg.dq_oe) [*3] ##1 pins_reg.we_n)
        else $error("write strobe width wrong");
    strobes_exclusive_a: assert property (@(posedge core_clk) disable iff (rst) // RL12
        !(!pins_reg.we_n && !pins_reg.oe_n))
        else $error("read and write strobes both low");
endmodule : fewc_bus_cycle
`default_nettype wire

/* File: src/fewc_host.sv */
// host controller that drives the flash command interface
// Contract
// RL1: device keeps error flags until clear
// RL2: clear is 50h, refused while suspended
// RL3: block erase is setup then confirm
// RL4: after operations reads return status
// RL5: bad confirm sets write and erase errors
// RL6: low supply erase sets voltage and erase
// RL7: boot blocks need protect pin high
// RL8: chip erase is 30h then d0h
// RL9: chip erase stops on error, unsuspendable
// RL10: chip erase error flags as block erase
// RL11: all locked chip erase flags lock
// RL12: byte write setup 40h then address data
// RL13: verify fails only on stuck ones
// RL14: byte write supply and lock errors
// RL15: erase suspend halts, sets ready and flag
// RL16: after suspend write 70h, check flag
// RL17: limited commands while erase suspended
// RL18: write during suspend shows ready low
// RL19: resume waits for suspend-time writes
// RL20: write suspend halts or reads array
// RL21: limited commands while write suspended
// RL22: hold reset and protect pins while suspended
// RL23: device reads array after reset
// RL24: suspend, resume single writes, resume d0h
// RL25: status latched on strobe fall
// RL26: busy device ignores other commands
// RL27: ready low until end or suspend
`timescale 1ns/10ps
`default_nettype none
module fewc_host
    import fewc_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic rst, // async reset
    input wire logic [fewc_pkg::REG_AW-1:0] reg_addr, // register address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data
    output fewc_pkg::fewc_pins_s flash_pins, // flash strobes, address, data
    input wire logic [fewc_pkg::DATA_W-1:0] flash_dq_in, // flash data pins
    output logic reset_powerdown_n, // flash reset pin
    output logic boot_protect // flash boot protect pin
);
    import fewc_pkg::*;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_C1 = 3'b001,
        ST_W1 = 3'b010,
        ST_C2 = 3'b011,
        ST_W2 = 3'b100,
        ST_RD = 3'b101,
        ST_WR = 3'b110
    } fewc_st_e;

    fewc_st_e state_reg, state_next;
    fewc_op_e op_reg, op_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic [DATA_W-1:0] status_reg, status_next;
    logic [DATA_W-1:0] rbyte_reg, rbyte_next;
    logic susp_reg, susp_next;
    logic refused_reg, refused_next;
    logic done_reg, done_next;
    logic rp_reg, rp_next;
    logic wp_reg, wp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic start_reg, start_next;
    logic cyc_read_reg, cyc_read_next;
    logic [DATA_W-1:0] cyc_data_reg, cyc_data_next;
    logic [DATA_W-1:0] dq_sync;
    logic [DATA_W-1:0] bus_byte;
    logic bus_done;
    logic go;
    fewc_op_e go_op;

    assign go = reg_wr && (reg_addr == REG_CTRL);
    assign go_op = fewc_op_e'(reg_wdata[3:0]);

    function automatic logic [DATA_W-1:0] first_cmd(input fewc_op_e op);
        case (op)
            OP_READ_ARRAY: first_cmd = CMD_READ_ARRAY;
            OP_READ_STATUS: first_cmd = CMD_READ_STATUS;
            OP_CLEAR: first_cmd = CMD_CLEAR_STATUS;
            OP_BLOCK_ERASE: first_cmd = CMD_BLOCK_ERASE;
            OP_CHIP_ERASE: first_cmd = CMD_CHIP_ERASE;
            OP_BYTE_WRITE: first_cmd = CMD_BYTE_WRITE;
            OP_SUSPEND: first_cmd = CMD_SUSPEND;
            default: first_cmd = CMD_CONFIRM;
        endcase
    endfunction : first_cmd

    function automatic logic has_second(input fewc_op_e op);
        has_second = (op == OP_BLOCK_ERASE) || (op == OP_CHIP_ERASE) ||
            (op == OP_BYTE_WRITE) || (op == OP_SUSPEND);
    endfunction : has_second

    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        status_next = status_reg;
        rbyte_next = rbyte_reg;
        susp_next = susp_reg;
        refused_next = refused_reg;
        done_next = done_reg;
        rp_next = rp_reg;
        wp_next = wp_reg;
        start_next = 1'b0;
        cyc_read_next = cyc_read_reg;
        cyc_data_next = cyc_data_reg;
        if (reg_wr && reg_addr == REG_ADDR) begin
            addr_next = reg_wdata[ADDR_W-1:0];
        end
        if (reg_wr && reg_addr == REG_WDATA) begin
            wdata_next = reg_wdata[DATA_W-1:0];
        end
        // pin levels frozen while an operation is suspended
        if (reg_wr && reg_addr == REG_PINS && !susp_reg) begin
            rp_next = reg_wdata[PIN_RP]; // RL22
            wp_next = reg_wdata[PIN_WP]; // RL22
        end
        case (state_reg)
            ST_IDLE: begin
                if (go) begin
                    if (go_op == OP_CLEAR && susp_reg) begin
                        refused_next = 1'b1; // RL2
                    end else begin
                        op_next = go_op;
                        refused_next = 1'b0;
                        done_next = 1'b0;
                        state_next = ST_C1;
                    end
                end
            end
            ST_C1: begin
                start_next = 1'b1;
                cyc_read_next = 1'b0;
                cyc_data_next = first_cmd(op_reg); // RL2 RL8 RL12 RL24
                state_next = ST_W1;
            end
            ST_W1: begin
                if (bus_done) begin
                    if (has_second(op_reg)) begin
                        state_next = ST_C2; // RL3
                    end else if (op_reg == OP_CLEAR) begin
                        done_next = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_RD; // RL24
                    end
                end
            end
            ST_C2: begin
                start_next = 1'b1;
                cyc_read_next = 1'b0;
                if (op_reg == OP_BYTE_WRITE) begin
                    cyc_data_next = wdata_reg; // RL12
                end else if (op_reg == OP_SUSPEND) begin
                    cyc_data_next = CMD_READ_STATUS; // RL16
                end else begin
                    cyc_data_next = CMD_CONFIRM; // RL3 RL8
                end
                state_next = ST_W2;
            end
            ST_W2: begin
                if (bus_done) begin
                    state_next = ST_RD;
                end
            end
            ST_RD: begin
                start_next = 1'b1;
                cyc_read_next = 1'b1;
                state_next = ST_WR;
            end
            ST_WR: begin
                if (bus_done) begin
                    if (op_reg == OP_READ_ARRAY) begin
                        rbyte_next = bus_byte;
                        done_next = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        status_next = bus_byte;
                        susp_next = bus_byte[BIT_ERASE_SUSP] | bus_byte[BIT_WRITE_SUSP]; // RL16
                        if (op_reg == OP_READ_STATUS || bus_byte[BIT_READY]) begin
                            done_next = 1'b1;
                            state_next = ST_IDLE;
                        end else begin
                            state_next = ST_RD;
                        end
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // a command written while busy is dropped and flagged
        if (go && state_reg != ST_IDLE) begin
            refused_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: rdata_next[3:0] = op_reg;
                REG_ADDR: rdata_next[ADDR_W-1:0] = addr_reg;
                REG_WDATA: rdata_next[DATA_W-1:0] = wdata_reg;
                REG_STATUS: begin
                    rdata_next[DATA_W-1:0] = status_reg;
                    rdata_next[STS_BUSY] = (state_reg != ST_IDLE);
                    rdata_next[STS_SUSP] = susp_reg;
                    rdata_next[STS_REFUSED] = refused_reg;
                    rdata_next[STS_DONE] = done_reg;
                end
                REG_RDATA: rdata_next[DATA_W-1:0] = rbyte_reg;
                REG_PINS: begin
                    rdata_next[PIN_RP] = rp_reg;
                    rdata_next[PIN_WP] = wp_reg;
                end
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_READ_ARRAY;
            addr_reg <= '0;
            wdata_reg <= '0;
            status_reg <= '0;
            rbyte_reg <= '0;
            susp_reg <= 1'b0;
            refused_reg <= 1'b0;
            done_reg <= 1'b0;
            rp_reg <= RP_RESET;
            wp_reg <= WP_RESET;
            rdata_reg <= 32'h00000000;
            start_reg <= 1'b0;
            cyc_read_reg <= 1'b0;
            cyc_data_reg <= '0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            status_reg <= status_next;
            rbyte_reg <= rbyte_next;
            susp_reg <= susp_next;
            refused_reg <= refused_next;
            done_reg <= done_next;
            rp_reg <= rp_next;
            wp_reg <= wp_next;
            rdata_reg <= rdata_next;
            start_reg <= start_next;
            cyc_read_reg <= cyc_read_next;
            cyc_data_reg <= cyc_data_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reset_powerdown_n = rp_reg;
    assign boot_protect = wp_reg;

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    fewc_sync #(.WIDTH(DATA_W)) u_dq_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d(flash_dq_in),
        .q(dq_sync)
    );

    fewc_bus_cycle u_bus (
        .core_clk(core_clk),
        .rst(rst),
        .start(start_reg),
        .is_read(cyc_read_reg),
        .cyc_addr(addr_reg),
        .cyc_data(cyc_data_reg),
        .dq_sync(dq_sync),
        .pins(flash_pins),
        .done(bus_done),
        .rd_byte(bus_byte)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    clear_refused_a: assert property (@(posedge core_clk) disable iff (rst) // RL2
        (state_reg == ST_IDLE && go && go_op == OP_CLEAR && susp_reg)
        |=> state_reg == ST_IDLE && refused_reg)
        else $error("clear issued while suspended");
    erase_confirm_a: assert property (@(posedge core_clk) disable iff (rst) // RL3
        (start_reg && state_reg == ST_W2 && op_reg == OP_BLOCK_ERASE)
        |-> cyc_data_reg == CMD_CONFIRM ##[1:8] !flash_pins.ce_n && flash_pins.addr == addr_reg)
        else $error("block erase confirm wrong");
    chip_setup_a: assert property (@(posedge core_clk) disable iff (rst) // RL8
        (start_reg && state_reg == ST_W1 && op_reg == OP_CHIP_ERASE)
        |-> cyc_data_reg == CMD_CHIP_ERASE)
        else $error("chip erase setup wrong");
    write_data_a: assert property (@(posedge core_clk) disable iff (rst) // RL12
        (start_reg && state_reg == ST_W2 && op_reg == OP_BYTE_WRITE)
        |-> cyc_data_reg == wdata_reg && !cyc_read_reg)
        else $error("byte write data wrong");
    write_setup_a: assert property (@(posedge core_clk) disable iff (rst) // RL12
        (start_reg && state_reg == ST_W1 && op_reg == OP_BYTE_WRITE)
        |-> cyc_data_reg == CMD_BYTE_WRITE)
        else $error("byte write setup wrong");
    suspend_status_a: assert property (@(posedge core_clk) disable iff (rst) // RL16
        (start_reg && state_reg == ST_W2 && op_reg == OP_SUSPEND)
        |-> cyc_data_reg == CMD_READ_STATUS)
        else $error("status command missing after suspend");
    pins_frozen_a: assert property (@(posedge core_clk) disable iff (rst) // RL22
        susp_reg |=> $stable(reset_powerdown_n) && $stable(boot_protect))
        else $error("pin changed while suspended");
    resume_single_a: assert property (@(posedge core_clk) disable iff (rst) // RL24
        (state_reg == ST_W1 && bus_done && op_reg == OP_RESUME)
        |=> state_reg == ST_RD ##1 state_reg == ST_WR && cyc_read_reg)
        else $error("resume not a single write");
endmodule : fewc_host
`default_nettype wire

/* File: src/fewc_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module fewc_sync #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk, // clock
    input wire logic rst, // async reset
    input wire logic [WIDTH-1:0] d, // pin level
    output logic [WIDTH-1:0] q // synced level
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule : fewc_sync
`default_nettype wire
